// *** rtl/demod_cfg_pkg.sv ***
package demod_cfg_pkg;

	// Register addresses within the host register space
	localparam logic [5:0] ADDR_DEMOD = 6'h19;
	localparam logic [5:0] ADDR_RSVD_1A = 6'h1a;
	localparam logic [5:0] ADDR_RSVD_1B = 6'h1b;
	localparam logic [5:0] ADDR_TX_TIMING = 6'h1c;
	localparam logic [5:0] ADDR_RX_PARITY = 6'h1d;
	localparam logic [5:0] ADDR_RSVD_1E = 6'h1e;
	localparam logic [5:0] ADDR_BAUD = 6'h1f;

	// Reset values
	localparam logic [7:0] RST_DEMOD = 8'h4d;
	localparam logic [7:0] RST_RSVD = 8'h00;
	localparam logic [7:0] RST_TX_TIMING = 8'h62;
	localparam logic [7:0] RST_RX_PARITY = 8'h00;
	localparam logic [7:0] RST_BAUD = 8'heb;

	// Field positions
	localparam int COMBINE_LSB = 6;
	localparam int FIXED_BIT = 5;
	localparam int EVEN_BIT = 4;
	localparam int TAU_RX_LSB = 2;
	localparam int TAU_BURST_LSB = 0;
	localparam int RESP_LSB = 0;
	localparam int PARITY_OFF_BIT = 4;
	localparam int COARSE_LSB = 5;
	localparam int FINE_LSB = 0;

	// Default response time added to the programmed field, in bit periods
	localparam logic [3:0] RESP_BASE_BITS = 4'h7;

	// Channel choice handed to the demodulator
	typedef enum logic [1:0]
	{
		CH_STRONGER = 2'h0,
		CH_STRONGER_HOLD = 2'h1,
		CH_FIXED_I = 2'h2,
		CH_FIXED_Q = 2'h3
	} chan_mode_e;

	// Host register access port
	typedef struct packed
	{
		logic wr_en;
		logic rd_en;
		logic [5:0] addr;
		logic [7:0] wdata;
	} host_req_s;

	// Decoded settings driven to the analog and framing logic
	typedef struct packed
	{
		chan_mode_e chan_mode;
		logic even_prescale_sel;
		logic [1:0] pll_rx_time_const;
		logic pll_rx_frozen;
		logic [1:0] pll_burst_time_const;
		logic [3:0] response_bits;
		logic parity_gen_en;
		logic parity_chk_en;
		logic parity_as_data;
		logic [2:0] baud_coarse_factor;
		logic [4:0] baud_fine_factor;
	} cfg_out_s;

endpackage

// *** rtl/demod_cfg_regs.sv ***
// Operation
// - Fixed bit clear: 00 picks stronger channel, 01 picks and holds it.
// - Stronger-channel modes apply only while fixed-channel bit is zero.
// - Fixed bit set: combine low bit 0 uses I, 1 uses Q.
// - Even select zero: timer divisor is twice prescaler plus one.
// - Even select one: timer divisor is twice prescaler plus two.
// - Even select bit resets to zero.
// - Receive time constant sets PLL during reception; 00 freezes it.
// - Burst time constant in bits 1..0 sets PLL during burst.
// - Response time is programmed field plus seven bit periods.
// - Parity-off bit 4 stops parity generation and checking.
// - With parity off, received parity bit passes as data.
// - Baud register: coarse factor bits 7..5, fine factor bits 4..0.
// - Baud register at 1Fh resets to EBh.
// - Demodulator register at 19h resets to 4Dh.
// - Transmit register at 1Ch resets to 62h, low two bits writable.
// - Receive register at 1Dh resets to 00h, parity enabled.
// - Reserved registers 1Ah, 1Bh, 1Eh reset to 00h, no function.
module demod_cfg_regs
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Host register port, same clock domain
	input demod_cfg_pkg::host_req_s host_req,
	output logic [7:0] host_rdata,
	// Receive-side hold request from the demodulator
	input wire logic comm_active,
	input wire logic q_stronger,
	// Decoded settings and live channel choice
	output demod_cfg_pkg::cfg_out_s cfg,
	output logic use_q_channel
);
	import demod_cfg_pkg::*;

	typedef struct packed
	{
		logic [7:0] demod;
		logic [1:0] resp;
		logic parity_off;
		logic [7:0] baud;
		logic [7:0] rdata;
		logic held_q;
		logic holding;
	} state_s;

	state_s st_ff;
	state_s nxt_st;

	// Read mux; reserved bits show their reset values
	function automatic logic [7:0] read_val(input state_s s, input logic [5:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			ADDR_DEMOD: v = s.demod;
			ADDR_TX_TIMING: v = {RST_TX_TIMING[7:2], s.resp};
			ADDR_RX_PARITY: v = {3'h0, s.parity_off, 4'h0};
			ADDR_BAUD: v = s.baud;
			default: v = RST_RSVD;
		endcase
		return v;
	endfunction

	// Register update, read capture and channel hold tracking
	always_comb
	begin
		nxt_st = st_ff;
		if (host_req.wr_en)
		begin
			unique case (host_req.addr)
				ADDR_DEMOD: nxt_st.demod = host_req.wdata;
				ADDR_TX_TIMING: nxt_st.resp = host_req.wdata[RESP_LSB +: 2];
				ADDR_RX_PARITY: nxt_st.parity_off = host_req.wdata[PARITY_OFF_BIT];
				ADDR_BAUD: nxt_st.baud = host_req.wdata;
				default: nxt_st.rdata = st_ff.rdata; // Reserved: write dropped
			endcase
		end
		if (host_req.rd_en)
		begin
			nxt_st.rdata = read_val(st_ff, host_req.addr);
		end
		// Latch the stronger channel at the start of a communication and keep it
		if (!comm_active)
		begin
			nxt_st.holding = 1'b0;
		end
		else if (!st_ff.holding)
		begin
			nxt_st.holding = 1'b1;
			nxt_st.held_q = q_stronger;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_ff.demod <= RST_DEMOD;
			st_ff.resp <= RST_TX_TIMING[1:0];
			st_ff.parity_off <= RST_RX_PARITY[PARITY_OFF_BIT];
			st_ff.baud <= RST_BAUD;
			st_ff.rdata <= 8'h00;
			st_ff.held_q <= 1'b0;
			st_ff.holding <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign host_rdata = st_ff.rdata;

	// Decoded fields. Reserved combine codes 1x behave like 0x since only the
	// low bit is looked at; software is expected not to write them.
	logic fixed;
	logic comb_lo;
	assign fixed = st_ff.demod[FIXED_BIT];
	assign comb_lo = st_ff.demod[COMBINE_LSB];

	always_comb
	begin
		if (fixed)
		begin
			cfg.chan_mode = comb_lo ? CH_FIXED_Q : CH_FIXED_I;
		end
		else
		begin
			cfg.chan_mode = comb_lo ? CH_STRONGER_HOLD : CH_STRONGER;
		end
		cfg.even_prescale_sel = st_ff.demod[EVEN_BIT];
		cfg.pll_rx_time_const = st_ff.demod[TAU_RX_LSB +: 2];
		cfg.pll_rx_frozen = (st_ff.demod[TAU_RX_LSB +: 2] == 2'h0);
		cfg.pll_burst_time_const = st_ff.demod[TAU_BURST_LSB +: 2];
		cfg.response_bits = RESP_BASE_BITS + {2'h0, st_ff.resp};
		cfg.parity_gen_en = !st_ff.parity_off;
		cfg.parity_chk_en = !st_ff.parity_off;
		cfg.parity_as_data = st_ff.parity_off;
		cfg.baud_coarse_factor = st_ff.baud[COARSE_LSB +: 3];
		cfg.baud_fine_factor = st_ff.baud[FINE_LSB +: 5];
	end

	// Live channel: fixed, held for the whole communication, or follow the stronger
	always_comb
	begin
		unique case (cfg.chan_mode)
			CH_FIXED_I: use_q_channel = 1'b0;
			CH_FIXED_Q: use_q_channel = 1'b1;
			CH_STRONGER_HOLD: use_q_channel = st_ff.holding ? st_ff.held_q : q_stronger;
			default: use_q_channel = q_stronger;
		endcase
	end

	// Checks run on the host clock. The reset-value group samples while reset is
	// held, so it sees the async reset directly; all the others are masked by reset.
	// Write checks look one edge after the strobe, matching the registered update.

	// Fixed mode ignores the detector entirely
	a_fixed_chan_sel: assert property (@(posedge clk) disable iff (!arst_n)
		fixed |-> (use_q_channel == comb_lo))
		else $error("fixed channel not honoured");

	// Once latched, the choice survives a change of the detector
	a_hold_keeps_q: assert property (@(posedge clk) disable iff (!arst_n)
		(st_ff.holding && comm_active && !fixed && comb_lo && !host_req.wr_en) ##1 st_ff.holding
		|-> use_q_channel == $past(use_q_channel))
		else $error("held channel changed");

	// Plain stronger mode tracks the detector every cycle
	a_stronger_follows: assert property (@(posedge clk) disable iff (!arst_n)
		(!fixed && !comb_lo) |-> use_q_channel == q_stronger)
		else $error("stronger channel not followed");

	// Response time always carries the base offset
	a_resp_plus_seven: assert property (@(posedge clk) disable iff (!arst_n)
		cfg.response_bits == 4'(7 + st_ff.resp))
		else $error("response time offset wrong");

	// Parity-off write reaches both the generator and the data path
	a_parity_write: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.wr_en && host_req.addr == ADDR_RX_PARITY) |=>
		(cfg.parity_gen_en == !$past(host_req.wdata[4]) && cfg.parity_as_data == $past(host_req.wdata[4])))
		else $error("parity off not applied");

	// All three reserved registers read as zero
	a_rsvd_reads_zero: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.rd_en && (host_req.addr == ADDR_RSVD_1A || host_req.addr == ADDR_RSVD_1B
		|| host_req.addr == ADDR_RSVD_1E)) |=> host_rdata == 8'h00)
		else $error("reserved register not zero");

	// Upper bits of the transmit register never move off their reset pattern
	a_tx_upper_fixed: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.rd_en && host_req.addr == ADDR_TX_TIMING) |=> host_rdata[7:2] == RST_TX_TIMING[7:2])
		else $error("reserved bits changed");

	// Write then read of the baud register returns the written byte
	a_baud_readback: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.wr_en && host_req.addr == ADDR_BAUD) ##1
		(host_req.rd_en && host_req.addr == ADDR_BAUD && !host_req.wr_en)
		|=> host_rdata == $past(host_req.wdata, 2))
		else $error("baud readback wrong");

	// Writing a zero receive time constant freezes the loop
	a_rx_freeze: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.wr_en && host_req.addr == ADDR_DEMOD) |=> cfg.pll_rx_frozen == ($past(host_req.wdata[3:2]) == 2'h0))
		else $error("pll freeze wrong");

	// Demodulator register shows its reset pattern while reset is held
	a_rst_demod_val: assert property (@(posedge clk)
		!arst_n |-> st_ff.demod == RST_DEMOD)
		else $error("demodulator reset value wrong");

	// Response field reset value
	a_rst_tx_val: assert property (@(posedge clk)
		!arst_n |-> st_ff.resp == RST_TX_TIMING[1:0])
		else $error("transmit reset value wrong");

	// Parity handling comes out of reset enabled
	a_rst_parity_val: assert property (@(posedge clk)
		!arst_n |-> (!st_ff.parity_off && cfg.parity_gen_en && cfg.parity_chk_en))
		else $error("parity reset value wrong");

	// Baud register reset value
	a_rst_baud_val: assert property (@(posedge clk)
		!arst_n |-> st_ff.baud == RST_BAUD)
		else $error("baud reset value wrong");

	// Odd divisor formula is the default after reset
	a_rst_even_zero: assert property (@(posedge clk)
		!arst_n |-> !cfg.even_prescale_sel)
		else $error("even select not clear in reset");

	// Setting the even select bit reaches the timer
	a_even_write: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.wr_en && host_req.addr == ADDR_DEMOD) |=> cfg.even_prescale_sel == $past(host_req.wdata[EVEN_BIT]))
		else $error("even select not applied");

	// Clearing it returns the timer to the odd divisor
	a_even_odd_formula: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.wr_en && host_req.addr == ADDR_DEMOD && !host_req.wdata[EVEN_BIT])
		|=> !cfg.even_prescale_sel)
		else $error("odd divisor not selected");

	// Receive time constant follows the written field
	a_rx_tc_write: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.wr_en && host_req.addr == ADDR_DEMOD) |=> cfg.pll_rx_time_const == $past(host_req.wdata[3:2]))
		else $error("receive time constant wrong");

	// Burst time constant follows bits one to zero
	a_burst_write: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.wr_en && host_req.addr == ADDR_DEMOD) |=> cfg.pll_burst_time_const == $past(host_req.wdata[1:0]))
		else $error("burst time constant wrong");

	// Coarse and fine baud factors split the written byte
	a_baud_fields: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.wr_en && host_req.addr == ADDR_BAUD)
		|=> {cfg.baud_coarse_factor, cfg.baud_fine_factor} == $past(host_req.wdata))
		else $error("baud factors wrong");

	// A write to a reserved register leaves every setting alone
	a_rsvd_write_quiet: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.wr_en && (host_req.addr == ADDR_RSVD_1A || host_req.addr == ADDR_RSVD_1B
		|| host_req.addr == ADDR_RSVD_1E)) |=> $stable(cfg))
		else $error("reserved write had an effect");

	// Only the parity-off bit of the receive register can read as one
	a_rx_upper_zero: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.rd_en && host_req.addr == ADDR_RX_PARITY)
		|=> (host_rdata[7:5] == 3'h0 && host_rdata[3:0] == 4'h0))
		else $error("receive reserved bits set");

	// With parity off the parity position is handed on as data
	a_parity_pair: assert property (@(posedge clk) disable iff (!arst_n)
		cfg.parity_as_data == !cfg.parity_chk_en)
		else $error("parity bit handling inconsistent");

	// Written response field plus base offset
	a_resp_write: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.wr_en && host_req.addr == ADDR_TX_TIMING)
		|=> cfg.response_bits == RESP_BASE_BITS + {2'h0, $past(host_req.wdata[1:0])})
		else $error("response time not applied");

	// Fixed bit always yields one of the two fixed modes
	a_fixed_mode_code: assert property (@(posedge clk) disable iff (!arst_n)
		fixed |-> (cfg.chan_mode == CH_FIXED_I || cfg.chan_mode == CH_FIXED_Q))
		else $error("fixed mode code wrong");

	// Reserved combine codes fall back to the stronger-channel modes
	a_rsvd_code_alias: assert property (@(posedge clk) disable iff (!arst_n)
		(!fixed && st_ff.demod[7])
		|-> cfg.chan_mode == (comb_lo ? CH_STRONGER_HOLD : CH_STRONGER))
		else $error("reserved combine code misdecoded");

	// Read data stands until the next read strobe
	a_rdata_holds: assert property (@(posedge clk) disable iff (!arst_n)
		!host_req.rd_en |=> $stable(host_rdata))
		else $error("read data moved without a read");

	// First cycle of a communication latches the detector
	a_latch_on_start: assert property (@(posedge clk) disable iff (!arst_n)
		(comm_active && !st_ff.holding)
		|=> (st_ff.holding && st_ff.held_q == $past(q_stronger)))
		else $error("channel not latched at start");

	// Hold is dropped as soon as the communication ends
	a_hold_clears: assert property (@(posedge clk) disable iff (!arst_n)
		!comm_active |=> !st_ff.holding)
		else $error("hold kept after communication");

	// All eight demodulator bits are stored
	a_demod_write: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.wr_en && host_req.addr == ADDR_DEMOD) |=> st_ff.demod == $past(host_req.wdata))
		else $error("demodulator write lost");

	// A read returns the value held before any same-cycle write
	a_rd_capture: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.rd_en && host_req.addr == ADDR_DEMOD) |=> host_rdata == $past(st_ff.demod))
		else $error("demodulator read wrong");

	// Baud read returns the stored byte
	a_rd_baud: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.rd_en && host_req.addr == ADDR_BAUD) |=> host_rdata == $past(st_ff.baud))
		else $error("baud read wrong");

	// Addresses outside this bank read as zero
	a_unmapped_zero: assert property (@(posedge clk) disable iff (!arst_n)
		(host_req.rd_en && (host_req.addr < ADDR_DEMOD || host_req.addr > ADDR_BAUD))
		|=> host_rdata == 8'h00)
		else $error("unmapped address not zero");

	// Freeze flag only when the field is zero
	a_rx_frozen_only_zero: assert property (@(posedge clk) disable iff (!arst_n)
		cfg.pll_rx_frozen |-> cfg.pll_rx_time_const == 2'h0)
		else $error("pll frozen with nonzero field");

	// Response time never drops below the base offset
	a_resp_floor: assert property (@(posedge clk) disable iff (!arst_n)
		cfg.response_bits >= RESP_BASE_BITS)
		else $error("response time below base");

endmodule

// *** tb/host_model.sv ***
// Host controller model: one-cycle strobes launched at the falling edge
module host_model
(
	// Clock
	input wire logic clk,
	// Request to the register bank
	output demod_cfg_pkg::host_req_s req,
	// Read data back from the bank
	input wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import demod_cfg_pkg::*;

	// Idle port until the first request
	initial req = '0;

	// Write strobe for exactly one rising edge
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req.wr_en = 1'b0;
	endtask

	// Data is registered on the strobe edge, so it is settled by the next falling edge
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(negedge clk);
		req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req.rd_en = 1'b0;
		d = rdata;
	endtask
endmodule

// *** tb/testbench.sv ***
// Register bank bench: reset map, masking, decode and channel choice
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import demod_cfg_pkg::*;

	logic clk = 1'b0;
	logic arst_n = 1'b1;
	logic comm_active = 1'b0;
	logic q_stronger = 1'b0;
	logic [7:0] rdata;
	logic [7:0] v;
	logic use_q;
	host_req_s req;
	cfg_out_s cfg;
	int error_cnt = 0;
	int num_checks = 0;
	logic [7:0] rst_exp [8] = '{8'h4d, 8'h00, 8'h00, 8'h62, 8'h00, 8'h00, 8'heb, 8'h00};

	// 50 MHz clock
	always #10 clk = ~clk;

	host_model host (.clk(clk), .req(req), .rdata(rdata));

	demod_cfg_regs DUT (.clk(clk), .arst_n(arst_n), .host_req(req), .host_rdata(rdata),
		.comm_active(comm_active), .q_stronger(q_stronger), .cfg(cfg), .use_q_channel(use_q));

	// Single comparison point
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t got %h want %h", $time, seen, exp);
		end
	endtask

	// Read a register and compare
	task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
		host.rd(a, v);
		chk(v, exp);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog well beyond the few dozen cycles the tests need
	initial
	begin
		#200000;
		error_cnt++;
		end_of_test();
	end

	initial
	begin
		// Real falling edge before the first clock edge so the async reset fires
		#1 arst_n = 1'b0;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		// Reset map, 20h stands for an unmapped address
		for (int i = 0; i < 8; i++)
			rchk(6'h19 + 6'(i), rst_exp[i]);
		chk({7'h0, cfg.even_prescale_sel}, 8'h00);
		chk({4'h0, cfg.response_bits}, 8'h09);
		$display("reset test done");
		// Writes into reserved places must not stick
		host.wr(6'h1c, 8'hff);
		rchk(6'h1c, 8'h63);
		chk({4'h0, cfg.response_bits}, 8'h0a);
		host.wr(6'h1d, 8'hff);
		rchk(6'h1d, 8'h10);
		chk({5'h0, cfg.parity_gen_en, cfg.parity_chk_en, cfg.parity_as_data}, 8'h01);
		host.wr(6'h1a, 8'hff);
		host.wr(6'h1e, 8'hff);
		rchk(6'h1a, 8'h00);
		rchk(6'h1e, 8'h00);
		host.wr(6'h1f, 8'h55);
		chk({cfg.baud_coarse_factor, cfg.baud_fine_factor}, 8'h55);
		rchk(6'h1f, 8'h55);
		$display("access test done");
		// Demodulator field decode
		host.wr(6'h19, 8'h1f);
		chk({1'b0, cfg.even_prescale_sel, cfg.pll_rx_time_const, cfg.pll_rx_frozen, 1'b0, cfg.pll_burst_time_const},
			8'h73);
		host.wr(6'h19, 8'h00);
		chk({7'h0, cfg.pll_rx_frozen}, 8'h01);
		// Fixed channel with low combine bit 0 then 1
		q_stronger = 1'b1;
		host.wr(6'h19, 8'h20);
		chk({5'h0, cfg.chan_mode, use_q}, 8'h04);
		host.wr(6'h19, 8'h60);
		q_stronger = 1'b0;
		@(negedge clk);
		chk({5'h0, cfg.chan_mode, use_q}, 8'h07);
		// Stronger channel follows the detector
		host.wr(6'h19, 8'h00);
		chk({7'h0, use_q}, 8'h00);
		q_stronger = 1'b1;
		@(negedge clk);
		chk({7'h0, use_q}, 8'h01);
		// Hold mode keeps the choice made at the start of a communication
		host.wr(6'h19, 8'h40);
		comm_active = 1'b1;
		@(negedge clk);
		q_stronger = 1'b0;
		@(negedge clk);
		chk({6'h0, cfg.chan_mode == CH_STRONGER_HOLD, use_q}, 8'h03);
		comm_active = 1'b0;
		@(negedge clk);
		chk({7'h0, use_q}, 8'h00);
		// Reserved combine code 10 acts as plain stronger mode
		host.wr(6'h19, 8'h80);
		chk({6'h0, cfg.chan_mode}, 8'h00);
		$display("channel test done");
		end_of_test();
	end
endmodule
